// ### dv/phy_status_and_irq_enable_tb_top.sv
// Self-checking bench for the transceiver status and interrupt enable block
`timescale 1ns/10ps
module phy_status_and_irq_enable_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc, stb, we, ack, int_o;
  logic [7:0] adr;
  logic [3:0] sel, chpol = 4'h0;
  logic [31:0] wdat, rdat;
  logic [1:0] rate = 2'h0;
  logic dup = 0, page = 0, res = 0, link = 0, cd = 0, ab = 0, ds = 0, slp = 0, pol = 1, jab = 0;
  logic [15:0] ev = 16'h0000, q;
  int num_errors = 0, num_checks = 0;
  // ==========================================================
  // Clock, design and bus master
  always #12.5 clk_i = ~clk_i;
  pss_status_irq dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .resolved_rate_field_i(rate), .full_duplex_i(dup), .page_rx_i(page), .neg_resolved_i(res),
    .link_up_i(link), .crossover_pairs_cd_i(cd), .crossover_pairs_ab_i(ab),
    .downshift_active_flag_i(ds), .sleep_i(slp), .channel_polarity_flags_i(chpol),
    .pol10_ok_i(pol), .jabber_i(jab), .events_i(ev), .int_o(int_o));
  pss_mgmt_master mst_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // A missing ack is a hang: counted, then the run is closed
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
    logic ok;
    mst_u.xfer(w, a, d, q, ok);
    if (!ok) begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic pulse_event(input logic [15:0] e);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= 16'h0000;
    repeat (3) @(posedge clk_i);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    access(0, 8'h44, 0); check(q, 16'h0002);
    access(0, 8'h48, 0); check(q, 16'h0000);
    access(0, 8'h50, 0); check(q, 16'h2000);
    check({15'h0, int_o}, 16'h0001);
    $display("reset test done");
  endtask
  // Every rate code, fields flipped per pass; second read must not clear jabber
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      rate <= i[1:0]; dup <= i[0]; res <= ~i[0]; link <= i[1]; cd <= i[0]; ab <= ~i[1];
      ds <= i[1]; slp <= ~i[0]; chpol <= {i[1:0], ~i[1:0]}; pol <= i[1]; jab <= i[0];
      repeat (2) @(posedge clk_i);
      repeat (2) begin
        access(0, 8'h44, 0);
        check(q, {i[1:0], i[0], 1'b0, ~i[0], i[1], i[0], ~i[1], i[1], ~i[0], i[1:0], ~i[1:0],
                  i[1], i[0]});
      end
    end
    $display("status test done");
  endtask
  task automatic t_page();
    @(posedge clk_i); page <= 1'b1;
    @(posedge clk_i); page <= 1'b0;
    repeat (2) @(posedge clk_i);
    access(0, 8'h44, 0); check(q[12], 1'b1);
    access(0, 8'h44, 0); check(q[12], 1'b0);
    $display("page test done");
  endtask
  task automatic t_enables();
    access(1, 8'h48, 16'hFFFF); access(0, 8'h48, 0);
    check(q, 16'hFD7F);
    access(1, 8'h48, 16'h0000); access(0, 8'h48, 0); check(q, 16'h0000);
    access(0, 8'h7C, 0); check(q, 16'h0000);
    $display("enable test done");
  endtask
  task automatic t_irq();
    pulse_event(16'h8001); check({15'h0, int_o}, 16'h0001);
    access(0, 8'h4C, 0); check(q, 16'h8001);
    access(0, 8'h4C, 0); check(q, 16'h0000);
    access(1, 8'h48, 16'h0001);
    pulse_event(16'h0001); check({15'h0, int_o}, 16'h0000);
    pulse_event(16'h0002); check({15'h0, int_o}, 16'h0000);
    access(0, 8'h4C, 0); check(q, 16'h0003);
    repeat (3) @(posedge clk_i);
    check({15'h0, int_o}, 16'h0001);
    access(1, 8'h50, 16'h0000);
    repeat (3) @(posedge clk_i);
    check({15'h0, int_o}, 16'h0000);
    pulse_event(16'h0001); check({15'h0, int_o}, 16'h0001);
    $display("interrupt test done");
  endtask
  // Events arriving while the clock enable is low are not captured
  task automatic t_freeze();
    @(posedge clk_i);
    ce_i <= 1'b0;
    pulse_event(16'h0004);
    check({15'h0, int_o}, 16'h0001);
    @(posedge clk_i);
    ce_i <= 1'b1;
    access(0, 8'h4C, 0);
    check(q, 16'h0001);
    repeat (3) @(posedge clk_i);
    check({15'h0, int_o}, 16'h0000);
    $display("freeze test done");
  endtask
  // A reset in mid-run puts back enables and polarity after they were written
  task automatic t_midreset();
    access(1, 8'h48, 16'h1234);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    access(0, 8'h48, 0);
    check(q, 16'h0000);
    access(0, 8'h50, 0);
    check(q, 16'h2000);
    check({15'h0, int_o}, 16'h0001);
    $display("mid-run reset test done");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_status();
    t_page();
    t_enables();
    t_irq();
    t_freeze();
    t_midreset();
    final_report();
  end
endmodule

// ### dv/pss_mgmt_master.sv
// Management controller model: classic Wishbone master for the status block
`timescale 1ns/10ps
module pss_mgmt_master (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'hA5A5_5A5A;
  end
  // One transfer: hold until ack is sampled high, bounded wait, then release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h3;
    dat_o <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 40);
    q = dat_i[15:0];
    ok = (ack_i === 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    dat_o <= ~dat_o; // Released data never keeps its last value
  endtask
endmodule

// ### hw/pss_pkg.sv
// Package: register map, field positions and reset values of the status block
package pss_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_STATE = 6'h11;
  localparam logic [5:0] IDX_IRQ_EN = 6'h12;
  localparam logic [5:0] IDX_PEND = 6'h13;
  localparam logic [5:0] IDX_CFG = 6'h14;
  localparam int ADR_W = 8;
  // ==========================================================
  // Status word fields
  localparam int ST_RATE_HI = 15;
  localparam int ST_RATE_LO = 14;
  localparam int ST_DUPLEX = 13;
  localparam int ST_PAGE = 12;
  localparam int ST_RESOLVED = 11;
  localparam int ST_LINK = 10;
  localparam int ST_CROSS_CD = 9;
  localparam int ST_CROSS_AB = 8;
  localparam int ST_DOWNSHIFT = 7;
  localparam int ST_SLEEP = 6;
  localparam int ST_CHPOL_HI = 5;
  localparam int ST_CHPOL_LO = 2;
  localparam int ST_POL10 = 1;
  localparam int ST_JABBER = 0;
  localparam logic [15:0] ST_RESET = 16'h0002;
  // Rate field codes
  localparam logic [1:0] RATE_10M = 2'h0;
  localparam logic [1:0] RATE_100M = 2'h1;
  localparam logic [1:0] RATE_1G = 2'h2;
  // ==========================================================
  // Enable and pending words: bits 9 and 7 are reserved
  localparam logic [15:0] EV_MASK = 16'hFD7F;
  localparam logic [15:0] EN_RESET = 16'h0000;
  localparam logic [15:0] PEND_RESET = 16'h0000;
  // ==========================================================
  // Configuration word: interrupt pin polarity
  localparam int CFG_INT_POL = 13;
  localparam logic [15:0] CFG_MASK = 16'h2000;
  localparam logic [15:0] CFG_RESET = 16'h2000;
endpackage

// ### hw/pss_status_irq.sv
// Transceiver status word and interrupt enables behind a classic Wishbone slave
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
module pss_status_irq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [1:0] resolved_rate_field_i,
  input wire logic full_duplex_i,
  input wire logic page_rx_i,
  input wire logic neg_resolved_i,
  input wire logic link_up_i,
  input wire logic crossover_pairs_cd_i,
  input wire logic crossover_pairs_ab_i,
  input wire logic downshift_active_flag_i,
  input wire logic sleep_i,
  input wire logic [3:0] channel_polarity_flags_i,
  input wire logic pol10_ok_i,
  input wire logic jabber_i,
  input wire logic [15:0] events_i,
  output logic int_o
);

  // ==========================================================
  // Register decode
  // Misaligned byte addresses fall to the unmapped answer.
  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr[7:2] == idx) && (adr[1:0] == 2'h0);
  endfunction

  // Byte-lane merge of a 16-bit register; only writable bits change
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel,
                                        input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
    merge = (old & ~lanes) | (wd[15:0] & lanes);
  endfunction

  logic [15:0] state_word;
  logic [15:0] irq_en;
  logic [15:0] pend;
  logic [15:0] cfg;

  // A request is taken once; ack high blocks a second take of the same cycle
  wire req = cyc_i && stb_i && !ack_o;
  wire take = ce_i && req;
  wire wr = take && we_i;
  wire rd = take && !we_i;
  wire sel_state = hit(adr_i, pss_pkg::IDX_STATE);
  wire sel_en = hit(adr_i, pss_pkg::IDX_IRQ_EN);
  wire sel_pend = hit(adr_i, pss_pkg::IDX_PEND);
  wire sel_cfg = hit(adr_i, pss_pkg::IDX_CFG);
  wire rd_state = rd && sel_state;
  wire rd_pend = rd && sel_pend;

  // ==========================================================
  // Status word
  // Live fields are resampled each enabled cycle so the output is a flop.
  wire [15:0] next_state_word = {
    resolved_rate_field_i,
    full_duplex_i,
    page_rx_i || (state_word[pss_pkg::ST_PAGE] && !rd_state),
    neg_resolved_i,
    link_up_i,
    crossover_pairs_cd_i,
    crossover_pairs_ab_i,
    downshift_active_flag_i,
    sleep_i,
    channel_polarity_flags_i,
    pol10_ok_i,
    jabber_i
  };

  // Reset puts polarity-correct in bit 1, everything else low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_word <= pss_pkg::ST_RESET;
    end else if (ce_i) begin
      state_word <= next_state_word;
    end
  end

  // ==========================================================
  // Enable and configuration words
  // Reserved enable bits are outside the write mask, so they stay 0.
  wire [15:0] next_irq_en = merge(irq_en, dat_i, sel_i, pss_pkg::EV_MASK);
  wire [15:0] next_cfg = merge(cfg, dat_i, sel_i, pss_pkg::CFG_MASK);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en <= pss_pkg::EN_RESET;
      cfg <= pss_pkg::CFG_RESET;
    end else if (wr) begin
      if (sel_en) begin
        irq_en <= next_irq_en;
      end
      if (sel_cfg) begin
        cfg <= next_cfg;
      end
    end
  end

  // ==========================================================
  // Pending event bits, cleared by a read of the pending word
  // A set arriving in the clearing cycle wins, so no event is lost.
  wire [15:0] next_pend;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_pend
      if (pss_pkg::EV_MASK[gi]) begin : g_live
        assign next_pend[gi] = events_i[gi] || (pend[gi] && !rd_pend);
      end else begin : g_rsvd
        assign next_pend[gi] = 1'b0;
      end
    end
  endgenerate

  // One register holds the whole word, so every bit has a single writer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= pss_pkg::PEND_RESET;
    end else if (ce_i) begin
      pend <= next_pend;
    end
  end

  // ==========================================================
  // Interrupt pin
  // Only enabled pending bits reach the pin; pending itself is ungated.
  wire irq_any = |(pend & irq_en);
  wire int_pol_low = cfg[pss_pkg::CFG_INT_POL];
  wire next_int = irq_any ? !int_pol_low : int_pol_low;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_o <= pss_pkg::CFG_RESET[pss_pkg::CFG_INT_POL];
    end else if (ce_i) begin
      int_o <= next_int;
    end
  end

  // ==========================================================
  // Bus answer
  // Data is captured at the taking edge, so the clear-on-read side
  // effect and the returned value come from the same snapshot.
  wire [15:0] rd_word = sel_state ? state_word :
                        sel_en ? irq_en :
                        sel_pend ? pend :
                        sel_cfg ? cfg : 16'h0000;
  wire [31:0] next_dat = {16'h0000, rd_word};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= req;
      if (rd) begin
        dat_o <= next_dat;
      end
    end
  end

  // ==========================================================
  // Checks
  chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && req && !rst_i) |=> ack_o)
    else $error("ack missing one cycle after request");

  chk_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ack_o) |=> !ack_o)
    else $error("ack held for more than one cycle");

  chk_rate_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rst_i) |=> state_word[15:14] == $past(resolved_rate_field_i))
    else $error("rate field does not follow its source");

  // Live status fields: each bit shows its input one enabled cycle later
  chk_duplex_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rst_i) |=> state_word[pss_pkg::ST_DUPLEX] == $past(full_duplex_i))
    else $error("duplex bit does not follow its source");

  chk_resolved_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rst_i) |=> state_word[pss_pkg::ST_RESOLVED] == $past(neg_resolved_i))
    else $error("resolution bit does not follow its source");

  chk_link_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rst_i) |=> state_word[pss_pkg::ST_LINK] == $past(link_up_i))
    else $error("link bit does not follow its source");

  chk_cross_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rst_i) |=> state_word[pss_pkg::ST_CROSS_CD -: 2] ==
    $past({crossover_pairs_cd_i, crossover_pairs_ab_i}))
    else $error("crossover bits do not follow their sources");

  chk_downshift_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rst_i) |=> state_word[pss_pkg::ST_DOWNSHIFT] == $past(downshift_active_flag_i))
    else $error("downshift bit does not follow its source");

  chk_sleep_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rst_i) |=> state_word[pss_pkg::ST_SLEEP] == $past(sleep_i))
    else $error("sleep bit does not follow its source");

  chk_chpol_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rst_i) |=> state_word[pss_pkg::ST_CHPOL_HI:pss_pkg::ST_CHPOL_LO] ==
    $past(channel_polarity_flags_i))
    else $error("channel polarity bits do not follow their sources");

  chk_pol10_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rst_i) |=> state_word[pss_pkg::ST_POL10] == $past(pol10_ok_i))
    else $error("10M polarity bit does not follow its source");

  chk_jabber_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rst_i) |=> state_word[pss_pkg::ST_JABBER] == $past(jabber_i))
    else $error("jabber bit does not follow its source");

  chk_page_latch_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rd_state && state_word[pss_pkg::ST_PAGE]) |=>
    state_word[pss_pkg::ST_PAGE])
    else $error("page flag lost without a status read");

  chk_page_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_state && !page_rx_i) ##1 !(ce_i && page_rx_i) |=>
    !state_word[pss_pkg::ST_PAGE])
    else $error("page flag not cleared by status read");

  chk_jabber_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_state && jabber_i) |=> state_word[pss_pkg::ST_JABBER])
    else $error("jabber mirror cleared by read");

  chk_rsvd_enables: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (!irq_en[9] && !irq_en[7] && !pend[9] && !pend[7]))
    else $error("reserved enable or pending bit set");

  chk_reset_values: assert property (@(posedge clk_i)
    rst_i |=> (irq_en == 16'h0000 && cfg[13] && state_word[1] && int_o))
    else $error("reset values wrong");

  chk_pend_ungated: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !rst_i && (events_i & pss_pkg::EV_MASK) != 16'h0000) |=>
    ((pend & $past(events_i & pss_pkg::EV_MASK)) ==
     $past(events_i & pss_pkg::EV_MASK)))
    else $error("event did not set its pending bit");

  chk_int_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> int_o == ($past(irq_any) ? !$past(int_pol_low) : $past(int_pol_low)))
    else $error("interrupt pin level wrong for polarity");

  chk_int_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && (pend & irq_en) == 16'h0000) |=> int_o == $past(int_pol_low))
    else $error("interrupt raised with no enabled pending event");

  chk_int_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && irq_any && !rd_pend && !wr) |=> irq_any)
    else $error("enabled pending event dropped without a read");

  // Enable and polarity writes land with the written lanes; reserved bits stay 0
  chk_en_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && sel_en && sel_i[1:0] == 2'h3) |=>
    irq_en == ($past(dat_i[15:0]) & pss_pkg::EV_MASK))
    else $error("enable word write not applied");

  chk_cfg_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && sel_cfg && sel_i[1]) |=>
    cfg[pss_pkg::CFG_INT_POL] == $past(dat_i[pss_pkg::CFG_INT_POL]))
    else $error("interrupt polarity write not applied");

  chk_pend_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_pend && (events_i & pss_pkg::EV_MASK) == 16'h0000) |=> !irq_any)
    else $error("interrupt source left after pending read");

  chk_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && !(sel_state || sel_en || sel_pend || sel_cfg)) |=> dat_o == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  chk_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ce_i && !rst_i) |=> ($stable(state_word) && $stable(pend) && $stable(irq_en) &&
    $stable(cfg) && $stable(ack_o) && $stable(int_o)))
    else $error("state changed while clock enable was low");

endmodule
